// ### lpmc_map.vh
// register offsets, field positions, reset values and timing counts of the mode controller
`ifndef LPMC_MAP_VH
`define LPMC_MAP_VH
`define LPMC_OSC_CTRL_OFF    12'h000
`define LPMC_PWR_CTRL_OFF    12'h004
`define LPMC_UNLOCK_OFF      12'h008
`define LPMC_STATUS_OFF      12'h00C
`define LPMC_PERIPH_OFF      12'h010
`define LPMC_WAKE_CFG_OFF    12'h014
`define LPMC_SLEEP_SEL_BIT   4
`define LPMC_REG_STBY_BIT    0
`define LPMC_RET_EN_BIT      1
`define LPMC_RET_CFG_BIT     2
`define LPMC_OSC_CTRL_RST    32'h0000_0000
`define LPMC_PWR_CTRL_RST    32'h0000_0000
`define LPMC_UNLOCK_KEY1     32'hAA99_6655
`define LPMC_UNLOCK_KEY2     32'h5566_99AA
`define LPMC_WAKE_CNT_RST    16'h0010
`define LPMC_STBY_EXTRA      16'h0040
`define LPMC_RET_EXTRA       16'h0100
`endif

// ### lpmc_sync.v
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module lpmc_sync #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;

  // first stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ### lpmc_ctrl.v
// low power mode controller: mode entry, clock gating, wake decision, apb registers
// Operation
// [RL1] sleep select plus wait enters sleep
// [RL2] sleep halts core, gates most peripheral clocks
// [RL3] fail safe monitor off during sleep
// [RL4] brownout detection stays enabled in sleep
// [RL5] sleep entry never clears watchdog count
// [RL6] listed sleep peripherals keep their clocks
// [RL7] oscillator dependent delay before core resumes
// [RL8] higher priority enabled interrupt wakes sleep
// [RL9] resets and watchdog time-out end modes
// [RL10] low priority interrupt moves sleep to idle
// [RL11] sleep select writes need unlock sequence
// [RL12] standby bit puts regulator to standby
// [RL13] standby sleep keeps all sleep peripherals
// [RL14] retention config clear plus enable: retention
// [RL15] retention keeps timer, watchdog, rtc, refclk only
// [RL16] master reset pin from retention gives por
// [RL17] sleep select clear plus wait enters idle
// [RL18] idle halts core, clocks stay enabled
// [RL19] stop in idle peripherals halt in idle
// [RL20] idle ends on higher priority interrupt
// [RL21] watchdog time-out interrupt ends idle
// [RL22] mode bits latched at wait execution
`timescale 1ns/1ns
`include "lpmc_map.vh"
module lpmc_ctrl #(
  parameter NPER = 8,
  parameter PW   = 3
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire            wait_exec,
  input  wire            irq_req,
  input  wire            irq_in_sleep,
  input  wire [PW-1:0]   irq_prio,
  input  wire [PW-1:0]   core_prio,
  input  wire            wdt_timeout,
  input  wire            master_reset_pin,
  input  wire            retention_regulator_config,
  input  wire [NPER-1:0] stop_in_idle,
  input  wire [NPER-1:0] sleep_capable,
  input  wire [NPER-1:0] retention_capable,
  output reg             core_clk_en,
  output reg  [NPER-1:0] periph_clk_en,
  output reg             peripheral_bus_clock_en,
  output reg             fail_safe_clock_monitor_en,
  output reg             brownout_reset_en,
  output reg             regulator_standby,
  output reg             retention_regulator_on,
  output reg             wdt_clear,
  output reg             por_request,
  output reg             pin_reset_request,
  output reg             core_wake
);
  // one-hot mode states
  localparam [5:0] ST_RUN   = 6'b00_0001;
  localparam [5:0] ST_IDLE  = 6'b00_0010;
  localparam [5:0] ST_SLEEP = 6'b00_0100;
  localparam [5:0] ST_STBY  = 6'b00_1000;
  localparam [5:0] ST_RET   = 6'b01_0000;
  localparam [5:0] ST_WAKE  = 6'b10_0000;

  reg [5:0]  state_r, state_nxt;
  reg        sleep_select_r;
  reg        regulator_standby_enable_r;
  reg        retention_enable_r;
  reg [1:0]  unlock_r;
  reg [15:0] wake_cnt_cfg_r;
  reg [15:0] wake_cnt_r, wake_cnt_nxt;
  reg        wake_seen_r;
  reg        pin_wake_r;
  wire       master_reset_pin_s;
  wire       wdt_s;
  wire       ret_cfg_s;

  ////////////////////////////////////////////////////////////////////////
  // pin inputs from outside the clock domain
  lpmc_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({master_reset_pin, wdt_timeout, retention_regulator_config}),
    .q       ({master_reset_pin_s, wdt_s, ret_cfg_s})
  );

  // priority compare shared by the wake decisions
  function prio_above;
    input [PW-1:0] a;
    input [PW-1:0] b;
    begin
      prio_above = (a > b);
    end
  endfunction

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire addr_ok = (paddr == `LPMC_OSC_CTRL_OFF) | (paddr == `LPMC_PWR_CTRL_OFF) |
                 (paddr == `LPMC_UNLOCK_OFF) | (paddr == `LPMC_STATUS_OFF) |
                 (paddr == `LPMC_PERIPH_OFF) | (paddr == `LPMC_WAKE_CFG_OFF);
  wire unlocked = (unlock_r == 2'b10);
  wire hi_irq   = irq_req & prio_above(irq_prio, core_prio);
  wire sleeping = (state_r == ST_SLEEP) | (state_r == ST_STBY) | (state_r == ST_RET);

  ////////////////////////////////////////////////////////////////////////
  // apb registers and unlock sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_select_r             <= 1'b0;
      regulator_standby_enable_r <= 1'b0;
      retention_enable_r         <= 1'b0;
      unlock_r                   <= 2'b00;
      wake_cnt_cfg_r             <= `LPMC_WAKE_CNT_RST;
    end else if (wr_acc) begin
      // [RL11] unlock key pair
      if (paddr == `LPMC_UNLOCK_OFF) begin
        if (pwdata == `LPMC_UNLOCK_KEY1)
          unlock_r <= 2'b01;
        else if (pwdata == `LPMC_UNLOCK_KEY2 && unlock_r == 2'b01)
          unlock_r <= 2'b10;
        else
          unlock_r <= 2'b00;
      end else if (paddr == `LPMC_OSC_CTRL_OFF) begin
        // [RL11] guarded sleep select
        if (unlocked)
          sleep_select_r <= pwdata[`LPMC_SLEEP_SEL_BIT];
        unlock_r <= 2'b00;
      end else if (paddr == `LPMC_PWR_CTRL_OFF) begin
        regulator_standby_enable_r <= pwdata[`LPMC_REG_STBY_BIT];
        retention_enable_r         <= pwdata[`LPMC_RET_EN_BIT];
      end else if (paddr == `LPMC_WAKE_CFG_OFF) begin
        wake_cnt_cfg_r <= pwdata[15:0];
      end
    end
  end

  // read mux and single-cycle answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `LPMC_OSC_CTRL_OFF: prdata <= {27'd0, sleep_select_r, 4'd0};
          `LPMC_PWR_CTRL_OFF: prdata <= {29'd0, ret_cfg_s, retention_enable_r,
                                         regulator_standby_enable_r};
          `LPMC_UNLOCK_OFF:   prdata <= {30'd0, unlock_r};
          `LPMC_STATUS_OFF:   prdata <= {24'd0, pin_wake_r, 1'b0, state_r};
          `LPMC_PERIPH_OFF:   prdata <= {{(32-NPER){1'b0}}, periph_clk_en};
          `LPMC_WAKE_CFG_OFF: prdata <= {16'd0, wake_cnt_cfg_r};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  wire unused_rd = rd_acc;

  ////////////////////////////////////////////////////////////////////////
  // mode state machine
  always @* begin
    state_nxt    = state_r;
    wake_cnt_nxt = wake_cnt_r;
    case (state_r)
      ST_RUN: begin
        if (wait_exec) begin
          // [RL22] mode latched at wait
          if (!sleep_select_r)
            // [RL17] idle entry
            state_nxt = ST_IDLE;
          // [RL14] retention entry
          else if (retention_enable_r && !ret_cfg_s)
            state_nxt = ST_RET;
          // [RL12] standby entry
          else if (regulator_standby_enable_r)
            state_nxt = ST_STBY;
          else
            // [RL1] sleep entry
            state_nxt = ST_SLEEP;
        end
      end
      ST_IDLE: begin
        // [RL20] [RL21] idle exit events
        if (hi_irq || wdt_s) begin
          state_nxt    = ST_WAKE;
          wake_cnt_nxt = 16'd1;
        end
      end
      ST_SLEEP, ST_STBY, ST_RET: begin
        // [RL8] [RL9] sleep exit events, [RL7] oscillator delay
        if ((irq_in_sleep && hi_irq) || wdt_s || master_reset_pin_s) begin
          state_nxt = ST_WAKE;
          if (state_r == ST_RET)
            wake_cnt_nxt = wake_cnt_cfg_r + `LPMC_RET_EXTRA;
          else if (state_r == ST_STBY)
            wake_cnt_nxt = wake_cnt_cfg_r + `LPMC_STBY_EXTRA;
          else
            wake_cnt_nxt = wake_cnt_cfg_r;
        end else if (irq_in_sleep && irq_req) begin
          // [RL10] low priority goes idle
          state_nxt = ST_IDLE;
        end
      end
      ST_WAKE: begin
        if (wake_cnt_r <= 16'd1)
          state_nxt = ST_RUN;
        else
          wake_cnt_nxt = wake_cnt_r - 16'd1;
      end
      default: state_nxt = ST_RUN;
    endcase
    // [RL9] master reset pin leaves any mode
    if (master_reset_pin_s && state_r != ST_RUN)
      state_nxt = ST_RUN;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_RUN;
      wake_cnt_r  <= 16'h0000;
      wake_seen_r <= 1'b0;
      pin_wake_r  <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      wake_cnt_r  <= wake_cnt_nxt;
      wake_seen_r <= (state_nxt == ST_RUN) & (state_r == ST_WAKE);
      if (master_reset_pin_s && state_r != ST_RUN)
        pin_wake_r <= 1'b1;
      else if (wait_exec)
        pin_wake_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered clock gates and regulator controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clk_en                <= 1'b1;
      periph_clk_en              <= {NPER{1'b1}};
      peripheral_bus_clock_en    <= 1'b1;
      fail_safe_clock_monitor_en <= 1'b1;
      brownout_reset_en          <= 1'b1;
      regulator_standby          <= 1'b0;
      retention_regulator_on     <= 1'b0;
      wdt_clear                  <= 1'b0;
      por_request                <= 1'b0;
      pin_reset_request          <= 1'b0;
      core_wake                  <= 1'b0;
    end else begin
      // [RL2] [RL18] core halted outside run
      core_clk_en <= (state_nxt == ST_RUN);
      // [RL2] peripheral bus clock stops in sleep
      peripheral_bus_clock_en <= ~((state_nxt == ST_SLEEP) | (state_nxt == ST_STBY) |
                                   (state_nxt == ST_RET));
      case (state_nxt)
        // [RL19] stop in idle
        ST_IDLE:  periph_clk_en <= ~stop_in_idle;
        // [RL6] [RL13] sleep capable set
        ST_SLEEP: periph_clk_en <= sleep_capable;
        ST_STBY:  periph_clk_en <= sleep_capable;
        // [RL15] restricted retention set
        ST_RET:   periph_clk_en <= retention_capable;
        default:  periph_clk_en <= {NPER{1'b1}};
      endcase
      // [RL3] monitor off in sleep
      fail_safe_clock_monitor_en <= ~((state_nxt == ST_SLEEP) | (state_nxt == ST_STBY) |
                                      (state_nxt == ST_RET));
      // [RL4] brownout always armed
      brownout_reset_en      <= 1'b1;
      // [RL12] regulator standby
      regulator_standby      <= (state_nxt == ST_STBY);
      retention_regulator_on <= (state_nxt == ST_RET);
      // [RL5] watchdog count kept
      wdt_clear              <= 1'b0;
      // [RL16] pin wake from retention
      por_request       <= master_reset_pin_s & (state_r == ST_RET);
      pin_reset_request <= master_reset_pin_s & (state_r != ST_RET);
      core_wake         <= wake_seen_r;
    end
  end
  wire unused_sl = sleeping;
endmodule

// ### lpmc_ctrl_sva.sv
// port assertions for the low power mode controller
`timescale 1ns/1ns
module lpmc_ctrl_sva #(
  parameter NPER = 8,
  parameter PW   = 3
) (
  input wire            pclk,
  input wire            presetn,
  input wire            wait_exec,
  input wire            irq_req,
  input wire            irq_in_sleep,
  input wire [PW-1:0]   irq_prio,
  input wire [PW-1:0]   core_prio,
  input wire            master_reset_pin,
  input wire [NPER-1:0] sleep_capable,
  input wire [NPER-1:0] retention_capable,
  input wire            core_clk_en,
  input wire [NPER-1:0] periph_clk_en,
  input wire            peripheral_bus_clock_en,
  input wire            fail_safe_clock_monitor_en,
  input wire            brownout_reset_en,
  input wire            regulator_standby,
  input wire            retention_regulator_on,
  input wire            wdt_clear,
  input wire            por_request,
  input wire            core_wake
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bor_active: assert property (brownout_reset_en)
    else $error("brownout detect off");
  a_wdt_kept: assert property (!wdt_clear)
    else $error("watchdog cleared");
  a_wait_halts: assert property (wait_exec && core_clk_en |=> !core_clk_en)
    else $error("core kept running after wait");
  a_fail_safe_clock_monitor_off: assert property (!peripheral_bus_clock_en |-> !fail_safe_clock_monitor_en)
    else $error("clock monitor on in sleep");
  a_run_clocks: assert property (core_clk_en |-> peripheral_bus_clock_en && &periph_clk_en)
    else $error("clock gated while running");
  a_sleep_gated: assert property (!peripheral_bus_clock_en |->
    (periph_clk_en & ~(sleep_capable | retention_capable)) == 0)
    else $error("sleep left a clock on");
  a_low_idle: assert property (!peripheral_bus_clock_en && irq_req && irq_in_sleep &&
    irq_prio <= core_prio |-> ##[1:4] (peripheral_bus_clock_en && !core_clk_en))
    else $error("low priority request mishandled");
  a_high_wake: assert property (irq_req && irq_prio > core_prio && !core_clk_en &&
    (irq_in_sleep || peripheral_bus_clock_en) |-> ##[1:400] core_clk_en)
    else $error("no wake on high priority");
  a_ret_por: assert property (retention_regulator_on && master_reset_pin |->
    ##[1:4] por_request)
    else $error("no power-on request");
  a_stby_halt: assert property (regulator_standby |-> !core_clk_en)
    else $error("core runs in standby");
  a_wake_pulse: assert property (core_wake |-> core_clk_en ##1 !core_wake)
    else $error("bad wake pulse");
  c_wait: cover property (wait_exec && core_clk_en);
  c_por: cover property (por_request);
  c_stby: cover property (regulator_standby);
endmodule
bind lpmc_ctrl lpmc_ctrl_sva #(.NPER(NPER), .PW(PW)) i_sva (.*);

// ### lpmc_core_model.sv
// core side model: executes the wait instruction on request
`timescale 1ns/1ns
module lpmc_core_model (
  input  wire pclk,
  input  wire presetn,
  input  wire go,
  input  wire core_clk_en,
  output reg  wait_exec
);
  // one wait per request, only from a clocked core
  // wait from running core
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wait_exec <= 1'b0;
    else
      wait_exec <= go && core_clk_en === 1'b1 && !wait_exec;
  end
endmodule

// ### lpmc_ctrl_tb.sv
// self-checking bench for the low power mode controller
`timescale 1ns/1ns
`include "lpmc_map.vh"
module lpmc_ctrl_tb;
  reg         pclk, presetn, psel, penable, pwrite, go, e, por_seen;
  reg         irq_req, irq_in_sleep, wdt_timeout, master_reset_pin;
  reg         retention_regulator_config;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, r;
  reg  [2:0]  irq_prio, core_prio;
  reg  [7:0]  stop_in_idle, sleep_capable, retention_capable;
  wire [31:0] prdata;
  wire [7:0]  periph_clk_en;
  wire        pready, pslverr, wait_exec, core_clk_en, peripheral_bus_clock_en;
  wire        fail_safe_clock_monitor_en, brownout_reset_en, regulator_standby;
  wire        retention_regulator_on, wdt_clear, por_request, pin_reset_request;
  wire        core_wake;
  integer     fail_count, n_compared, n;
  lpmc_ctrl i_dut (.*);
  lpmc_core_model i_core (.*);
  always #2 pclk = ~pclk;
  // latch any power-on request
  always @(posedge pclk) if (por_request === 1'b1) por_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [31:0] x, input [31:0] got);
    n_compared = n_compared + 1;
    if (got !== x) begin
      $display("MISMATCH %0s expected %h seen %h", nm, x, got);
      fail_count = fail_count + 1;
    end
  endtask
  // one apb transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task unl(input [31:0] v);
    apb(1, `LPMC_UNLOCK_OFF, `LPMC_UNLOCK_KEY1);
    apb(1, `LPMC_UNLOCK_OFF, `LPMC_UNLOCK_KEY2);
    apb(1, `LPMC_OSC_CTRL_OFF, v);
  endtask
  task enter;
    @(posedge pclk) go <= 1'b1;
    @(posedge pclk) go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task state(input [31:0] x);
    apb(0, `LPMC_STATUS_OFF, 0);
    chk("state", x, r & 32'h0000_003f);
  endtask
  task wake(input integer lo, input integer hi);
    n = 0;
    while (core_clk_en !== 1'b1) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk("wake_time", 1, n >= lo && n <= hi);
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count = fail_count + 1;
    close_out;
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, go, por_seen} = 0;
    {irq_req, irq_in_sleep, wdt_timeout, master_reset_pin} = 0;
    {retention_regulator_config, paddr, pwdata} = 0;
    fail_count = 0;
    n_compared = 0;
    r = $urandom(26);
    sleep_capable = $urandom;
    stop_in_idle = $urandom;
    retention_capable = $urandom & sleep_capable;
    core_prio = 1 + $urandom % 6;
    irq_prio = core_prio;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `LPMC_WAKE_CFG_OFF, 0);
    chk("wake_rst", `LPMC_WAKE_CNT_RST, r);
    apb(0, 12'h020, 0);
    chk("slverr", 1, e);
    apb(1, `LPMC_OSC_CTRL_OFF, 32'h0000_0010);
    apb(0, `LPMC_OSC_CTRL_OFF, 0);
    chk("locked", `LPMC_OSC_CTRL_RST, r);
    unl(32'h0000_0010);
    apb(0, `LPMC_OSC_CTRL_OFF, 0);
    chk("unlocked", 32'h0000_0010, r);
    $display("done registers");
    enter;
    state(4);
    chk("fail_safe_clock_monitor", 0, fail_safe_clock_monitor_en);
    chk("bor", 1, brownout_reset_en);
    chk("wdt_clr", 0, wdt_clear);
    apb(0, `LPMC_PERIPH_OFF, 0);
    chk("sleep_clk", sleep_capable, r);
    unl(0);
    state(4);
    irq_req <= 1'b1;
    irq_in_sleep <= 1'b1;
    repeat (6) @(posedge pclk);
    state(2);
    irq_prio <= core_prio + 1;
    wake(0, 8);
    irq_req <= 1'b0;
    unl(32'h0000_0010);
    enter;
    irq_req <= 1'b1;
    wake(16, 40);
    // wake pulse follows the core clock by one cycle
    @(posedge pclk);
    chk("core_wake", 1, core_wake);
    irq_req <= 1'b0;
    $display("done sleep");
    apb(1, `LPMC_PWR_CTRL_OFF, 1);
    enter;
    state(8);
    chk("stby", 1, regulator_standby);
    apb(0, `LPMC_PERIPH_OFF, 0);
    chk("stby_clk", sleep_capable, r);
    wdt_timeout <= 1'b1;
    wake(76, 120);
    wdt_timeout <= 1'b0;
    $display("done standby");
    apb(1, `LPMC_PWR_CTRL_OFF, 3);
    enter;
    state(16);
    chk("ret_on", 1, retention_regulator_on);
    apb(0, `LPMC_PERIPH_OFF, 0);
    chk("ret_clk", retention_capable, r);
    master_reset_pin <= 1'b1;
    wake(0, 8);
    // let the latch of the power-on request settle
    @(posedge pclk);
    chk("por", 1, por_seen);
    master_reset_pin <= 1'b0;
    $display("done retention");
    apb(1, `LPMC_PWR_CTRL_OFF, 0);
    unl(0);
    irq_prio <= core_prio;
    irq_in_sleep <= 1'b0;
    enter;
    state(2);
    chk("idle_bus", 1, peripheral_bus_clock_en);
    apb(0, `LPMC_PERIPH_OFF, 0);
    chk("idle_clk", {24'h0, ~stop_in_idle}, r);
    irq_req <= 1'b1;
    repeat (6) @(posedge pclk);
    state(2);
    wdt_timeout <= 1'b1;
    wake(0, 8);
    wdt_timeout <= 1'b0;
    irq_req <= 1'b0;
    $display("done idle");
    close_out;
  end
endmodule
